// ### include/port_power_pkg.sv
// What this block does
// [RQ1] one two-way power control pin per downstream port, ports seven down to four
// [RQ2] enabled port: pin is an input with internal pull-up on
// [RQ3] enabled port: pulled-up pin level switches on the port's power
// [RQ4] enabled port: low pin level is an overcurrent on that port
// [RQ5] port disabled by configuration or host: pin becomes an output driven low
// [RQ6] names ending in _n are asserted at low level
// [RQ7] names without _n are asserted at high level
// [RQ8] sensed bus power gates the upstream connection
// [RQ9] bus power toggle renegotiates the upstream connection, no full reset
// [RQ10] ganged mode: one shared pin controls power for all ports
// [RQ11] synchronise pins, latch overcurrent flags until acknowledged
package port_power_pkg;
	// ***********************************************************
	// sizes and timing
	// ***********************************************************
	localparam int port_count = 4;
	localparam int first_port = 4;
	// bus power must be stable this long before connecting
	localparam int settle_time_ns = 1000;
	localparam int clk_period_ns = 10;
	localparam int settle_cycles = (settle_time_ns + clk_period_ns - 1) / clk_period_ns;
	// renegotiation holds the disconnect at least this long
	localparam int reneg_time_ns = 500;
	localparam int reneg_cycles = (reneg_time_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int count_width = 8;
	// ***********************************************************
	// reset values
	// ***********************************************************
	localparam logic [port_count-1:0] flags_reset = 4'h0;
	localparam logic [count_width-1:0] count_reset = 8'h00;

	// upstream connection states
	typedef enum logic [3:0] {
		up_idle = 4'b0001,
		up_settle = 4'b0010,
		up_connected = 4'b0100,
		up_reneg = 4'b1000
	} up_state_type;
endpackage : port_power_pkg

// ### logic/pin_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a bank of pins
module pin_sync #(
	parameter int width = 1
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [width-1:0] async_in,
	input wire logic [width-1:0] reset_level,
	output logic [width-1:0] sync_out
);
	logic [width-1:0] stage_one;
	logic [width-1:0] next_stage_one;
	logic [width-1:0] next_sync_out;

	// next values; reset level is a fixed constant at every instance
	always_comb begin
		next_stage_one = async_in;
		next_sync_out = stage_one;
	end

	// first stage read only by the second
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stage_one <= reset_level;
			sync_out <= reset_level;
		end else begin
			stage_one <= next_stage_one;
			sync_out <= next_sync_out;
		end
	end
endmodule : pin_sync

// ### logic/port_power_ctl.sv
`timescale 1ns/1ps
module port_power_ctl (
	input wire logic clk_sys,
	input wire logic sys_rst,
	// per-port enable from configuration, bit 0 is port 4
	input wire logic [port_power_pkg::port_count-1:0] cfg_port_enable,
	// per-port enable from host port-power commands
	input wire logic [port_power_pkg::port_count-1:0] host_port_enable,
	// ganged port power mode select
	input wire logic gang_mode,
	// pin input levels of port7..port4 power control pins
	input wire logic [port_power_pkg::port_count-1:0] port_power_ctl_in,
	output logic [port_power_pkg::port_count-1:0] port_power_ctl_out,
	output logic [port_power_pkg::port_count-1:0] port_power_ctl_oe,
	output logic [port_power_pkg::port_count-1:0] port_power_ctl_pullup,
	// shared gang power pin, a pin of its own; all four port pins are parked low in ganged mode
	input wire logic shared_port_power_ctl_in,
	output logic shared_port_power_ctl_out,
	output logic shared_port_power_ctl_oe,
	output logic shared_port_power_ctl_pullup,
	// bus power sense pin
	input wire logic bus_power_sense,
	// per-port overcurrent acknowledge pulse
	input wire logic [port_power_pkg::port_count-1:0] oc_ack,
	output logic [port_power_pkg::port_count-1:0] oc_live,
	output logic [port_power_pkg::port_count-1:0] oc_flag,
	output logic [port_power_pkg::port_count-1:0] port_powered,
	output logic upstream_connect,
	output logic reneg_pulse
);
	import port_power_pkg::*;

	// ***********************************************************
	// pin synchronisers
	// ***********************************************************
	logic [port_count+1:0] raw_pins;
	logic [port_count+1:0] sync_pins;
	logic [port_count-1:0] pin_level;
	logic shared_level;
	logic bus_power;

	assign raw_pins = {bus_power_sense, shared_port_power_ctl_in, port_power_ctl_in};

	// pins idle high through pull-ups; bus power assumed absent at reset
	// [RQ11] sync every pin
	pin_sync #(
		.width(port_count + 2)
	) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.async_in(raw_pins),
		.reset_level({1'b0, {(port_count + 1){1'b1}}}),
		.sync_out(sync_pins)
	);

	assign pin_level = sync_pins[port_count-1:0];
	assign shared_level = sync_pins[port_count];
	// [RQ7] sense is active high
	assign bus_power = sync_pins[port_count+1];

	// ***********************************************************
	// port pin drive and overcurrent
	// ***********************************************************
	logic [port_count-1:0] enabled;
	logic gang_enabled;
	logic [port_count-1:0] next_out;
	logic [port_count-1:0] next_oe;
	logic [port_count-1:0] next_pullup;
	logic next_shared_out;
	logic next_shared_oe;
	logic next_shared_pullup;
	logic [port_count-1:0] next_live;
	logic [port_count-1:0] next_flag;
	logic [port_count-1:0] next_powered;
	// pull-up age; a pin the device itself held low must pass both sync stages before it counts
	logic [port_count-1:0] armed_one;
	logic [port_count-1:0] armed_two;
	logic [port_count-1:0] next_armed_one;
	logic [port_count-1:0] next_armed_two;
	logic shared_armed_one;
	logic shared_armed_two;
	logic next_shared_armed_one;
	logic next_shared_armed_two;

	// [RQ5] either source may disable a port
	assign enabled = cfg_port_enable & host_port_enable;
	// ganged: any enabled port powers the whole group
	assign gang_enabled = |enabled;

	always_comb begin
		next_out = '0;
		next_oe = '0;
		next_pullup = '0;
		next_shared_out = 1'b0;
		next_shared_oe = 1'b0;
		next_shared_pullup = 1'b0;
		next_live = '0;
		// [RQ4] arm sensing two cycles after release
		next_armed_one = port_power_ctl_pullup;
		next_armed_two = armed_one & port_power_ctl_pullup;
		next_shared_armed_one = shared_port_power_ctl_pullup;
		next_shared_armed_two = shared_armed_one & shared_port_power_ctl_pullup;
		if (gang_mode) begin
			// [RQ10] shared pin controls all ports
			next_shared_pullup = gang_enabled;
			next_shared_oe = !gang_enabled;
			// [RQ4] low level is overcurrent on all ports
			next_live = {port_count{gang_enabled & shared_armed_two & !shared_level}};
			// individual pins parked low while ganged
			next_oe = '1;
		end else begin
			// [RQ1] one pin per port
			for (int i = 0; i < port_count; i++) begin
				// [RQ2] input with pull-up, [RQ3] pull-up powers port
				next_pullup[i] = enabled[i];
				// [RQ5] disabled drives low
				next_oe[i] = !enabled[i];
				// [RQ6] active-low overcurrent sense
				next_live[i] = enabled[i] & armed_two[i] & !pin_level[i];
			end
		end
		next_powered = gang_mode ? {port_count{gang_enabled}} : enabled;
		// [RQ11] set wins over acknowledge
		next_flag = (oc_flag & ~oc_ack) | next_live;
	end

	// pin drive registered so outputs come from flops
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			port_power_ctl_out <= '0;
			port_power_ctl_oe <= '1;
			port_power_ctl_pullup <= '0;
			shared_port_power_ctl_out <= 1'b0;
			shared_port_power_ctl_oe <= 1'b1;
			shared_port_power_ctl_pullup <= 1'b0;
			oc_live <= flags_reset;
			oc_flag <= flags_reset;
			port_powered <= flags_reset;
			armed_one <= flags_reset;
			armed_two <= flags_reset;
			shared_armed_one <= 1'b0;
			shared_armed_two <= 1'b0;
		end else begin
			port_power_ctl_out <= next_out;
			port_power_ctl_oe <= next_oe;
			port_power_ctl_pullup <= next_pullup;
			shared_port_power_ctl_out <= next_shared_out;
			shared_port_power_ctl_oe <= next_shared_oe;
			shared_port_power_ctl_pullup <= next_shared_pullup;
			oc_live <= next_live;
			oc_flag <= next_flag;
			port_powered <= next_powered;
			armed_one <= next_armed_one;
			armed_two <= next_armed_two;
			shared_armed_one <= next_shared_armed_one;
			shared_armed_two <= next_shared_armed_two;
		end
	end

	// ***********************************************************
	// upstream connection
	// ***********************************************************
	localparam logic [count_width-1:0] settle_last = count_width'(settle_cycles - 1);
	localparam logic [count_width-1:0] reneg_last = count_width'(reneg_cycles - 1);

	up_state_type state;
	up_state_type next_state;
	logic [count_width-1:0] count;
	logic [count_width-1:0] next_count;
	logic next_connect;
	logic next_reneg;

	always_comb begin
		next_state = state;
		next_count = count;
		next_reneg = 1'b0;
		case (state)
			up_idle: begin
				next_count = count_reset;
				if (bus_power) begin
					next_state = up_settle;
				end
			end
			// [RQ8] connect only after bus power stays present
			up_settle: begin
				if (!bus_power) begin
					next_state = up_idle;
				end else if (count == settle_last) begin
					next_state = up_connected;
					next_count = count_reset;
				end else begin
					next_count = count + 8'h01;
				end
			end
			// [RQ9] power drop starts renegotiation, no reset
			up_connected: begin
				if (!bus_power) begin
					next_state = up_reneg;
					next_count = count_reset;
					next_reneg = 1'b1;
				end
			end
			// hold disconnect a minimum time so the host sees it
			up_reneg: begin
				if (count == reneg_last) begin
					next_state = up_idle;
					next_count = count_reset;
				end else begin
					next_count = count + 8'h01;
				end
			end
			default: begin
				next_state = up_idle;
				next_count = count_reset;
			end
		endcase
		next_connect = (next_state == up_connected);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= up_idle;
			count <= count_reset;
			upstream_connect <= 1'b0;
			reneg_pulse <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			upstream_connect <= next_connect;
			reneg_pulse <= next_reneg;
		end
	end
endmodule : port_power_ctl

// ### verif/power_ctl_props.sv
`timescale 1ns/1ps
// ******
// pin and upstream checker
// ******
module power_ctl_props import port_power_pkg::*; (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [port_count-1:0] cfg_port_enable,
	input wire logic [port_count-1:0] host_port_enable,
	input wire logic gang_mode,
	input wire logic [port_count-1:0] port_power_ctl_in,
	input wire logic [port_count-1:0] port_power_ctl_out,
	input wire logic [port_count-1:0] port_power_ctl_oe,
	input wire logic [port_count-1:0] port_power_ctl_pullup,
	input wire logic shared_port_power_ctl_in,
	input wire logic bus_power_sense,
	input wire logic [port_count-1:0] oc_ack,
	input wire logic [port_count-1:0] oc_live,
	input wire logic [port_count-1:0] oc_flag,
	input wire logic upstream_connect,
	input wire logic reneg_pulse
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [port_count-1:0] en;
	// a port is on only when both config and host agree
	assign en = cfg_port_enable & host_port_enable;
	// released pin pulled low long enough to pass the two sync stages
	sequence s_oc0;
		(en[0] && !gang_mode && port_power_ctl_pullup[0] && !port_power_ctl_in[0])[*3];
	endsequence
	// the pin watched in the current mode stays high, mode unchanged
	sequence s_quiet0;
		((gang_mode ? shared_port_power_ctl_in : port_power_ctl_in[0]) && $stable(gang_mode))[*3];
	endsequence
	a_out_low: assert property (port_power_ctl_out == 4'h0) else $error("pin output not low");
	a_off_drives: assert property (!gang_mode |=> port_power_ctl_oe == ~$past(en)) else $error("oe wrong");
	a_on_pullup: assert property (!gang_mode |=> port_power_ctl_pullup == $past(en)) else $error("pullup wrong");
	a_gang_drive: assert property (gang_mode |=> port_power_ctl_oe == 4'hf) else $error("gang oe wrong");
	a_oc_seen: assert property (s_oc0 |=> oc_live[0] && oc_flag[0]) else $error("overcurrent missed");
	a_flag_sticky: assert property (1 |=> ($past(oc_flag & ~oc_ack) & ~oc_flag) == 4'h0) else $error("flag lost");
	a_ack_clear: assert property ((s_quiet0 ##0 oc_ack[0] && !oc_live[0]) |=> !oc_flag[0]) else $error("ack ignored");
	a_connect_settle: assert property ($rose(upstream_connect) |-> $past(bus_power_sense, 100)) else $error("early");
	a_drop_reneg: assert property ($fell(upstream_connect) |-> ##[0:1] (reneg_pulse ##1 !reneg_pulse))
		else $error("no reneg pulse");
endmodule : power_ctl_props
bind port_power_ctl power_ctl_props props_inst (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.cfg_port_enable(cfg_port_enable),
	.host_port_enable(host_port_enable),
	.gang_mode(gang_mode),
	.port_power_ctl_in(port_power_ctl_in),
	.port_power_ctl_out(port_power_ctl_out),
	.port_power_ctl_oe(port_power_ctl_oe),
	.port_power_ctl_pullup(port_power_ctl_pullup),
	.shared_port_power_ctl_in(shared_port_power_ctl_in),
	.bus_power_sense(bus_power_sense),
	.oc_ack(oc_ack),
	.oc_live(oc_live),
	.oc_flag(oc_flag),
	.upstream_connect(upstream_connect),
	.reneg_pulse(reneg_pulse)
);

// ### verif/port_switch_model.sv
`timescale 1ns/1ps
// ******
// external power switch and current monitor
// ******
module port_switch_model #(
	parameter int width = 4
) (
	input wire logic [width-1:0] oe,
	input wire logic [width-1:0] out,
	input wire logic [width-1:0] pull_up,
	input wire logic [width-1:0] oc_cmd,
	output logic [width-1:0] pin_level,
	output logic [width-1:0] power_on
);
	// monitor pulls pin low
	// a released pin with no pull-up sinks to low through the switch input
	assign pin_level = (oe & out) | (~oe & ~oc_cmd & pull_up);
	assign power_on = pin_level & ~oe;
endmodule : port_switch_model

// ### verif/port_power_ctl_bench.sv
`timescale 1ns/1ps
module port_power_ctl_bench;
	import port_power_pkg::*;
	logic clk_sys = 0, sys_rst = 1, gang_mode = 0, bus_power_sense = 0, shared_oc = 0;
	logic shared_port_power_ctl_in, shared_port_power_ctl_out, shared_port_power_ctl_oe;
	logic shared_port_power_ctl_pullup, upstream_connect, reneg_pulse;
	logic [3:0] cfg_port_enable = 0, host_port_enable = 0, oc_ack = 0, oc_cmd = 0, sw_power;
	logic [3:0] port_power_ctl_in, port_power_ctl_out, port_power_ctl_oe, port_power_ctl_pullup;
	logic [3:0] oc_live, oc_flag, port_powered;
	int n_fail = 0, checked = 0, n;
	always #5 clk_sys = ~clk_sys;
	port_power_ctl port_power_ctl_inst (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.cfg_port_enable(cfg_port_enable),
		.host_port_enable(host_port_enable),
		.gang_mode(gang_mode),
		.port_power_ctl_in(port_power_ctl_in),
		.port_power_ctl_out(port_power_ctl_out),
		.port_power_ctl_oe(port_power_ctl_oe),
		.port_power_ctl_pullup(port_power_ctl_pullup),
		.shared_port_power_ctl_in(shared_port_power_ctl_in),
		.shared_port_power_ctl_out(shared_port_power_ctl_out),
		.shared_port_power_ctl_oe(shared_port_power_ctl_oe),
		.shared_port_power_ctl_pullup(shared_port_power_ctl_pullup),
		.bus_power_sense(bus_power_sense),
		.oc_ack(oc_ack),
		.oc_live(oc_live),
		.oc_flag(oc_flag),
		.port_powered(port_powered),
		.upstream_connect(upstream_connect),
		.reneg_pulse(reneg_pulse)
	);
	port_switch_model port_switch_model_inst (.oe(port_power_ctl_oe), .out(port_power_ctl_out),
		.pull_up(port_power_ctl_pullup), .oc_cmd(oc_cmd), .pin_level(port_power_ctl_in), .power_on(sw_power));
	port_switch_model #(.width(1)) shared_model_inst (.oe(shared_port_power_ctl_oe),
		.out(shared_port_power_ctl_out), .pull_up(shared_port_power_ctl_pullup), .oc_cmd(shared_oc),
		.pin_level(shared_port_power_ctl_in), .power_on());
	// ******
	// helpers
	// ******
	task step(input int k);
		repeat (k) @(negedge clk_sys);
	endtask : step
	task check(input logic [3:0] seen, input logic [3:0] want);
		checked++;
		if (seen !== want) begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask : check
	task stop_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	// bounded wait; running out ends the run
	task wait_connect;
		n = 0;
		while (upstream_connect !== 1'b1 && n < 300) begin
			step(1);
			n++;
		end
		if (upstream_connect !== 1'b1) begin
			n_fail++;
			stop_test();
		end
	endtask : wait_connect
	// ******
	// scenarios
	// ******
	task t_enable;
		for (int i = 0; i < 4; i++) begin
			cfg_port_enable = 4'hf;
			host_port_enable = 4'hf ^ (4'h1 << i);
			step(2);
			check(port_power_ctl_oe, 4'h1 << i);
			check(port_powered, 4'hf ^ (4'h1 << i));
			cfg_port_enable = 4'h1 << i;
			host_port_enable = 4'hf;
			step(2);
			check(port_power_ctl_oe, 4'hf ^ (4'h1 << i));
			check(port_power_ctl_pullup, 4'h1 << i);
			check(sw_power, 4'h1 << i);
			check(port_powered, 4'h1 << i);
			step(2);
			// own low drive before release is no overcurrent
			check(oc_flag, 4'h0);
		end
		$display("test enable done");
	endtask : t_enable
	task t_oc;
		cfg_port_enable = 4'hf;
		for (int i = 0; i < 4; i++) begin
			oc_cmd = 4'h1 << i;
			step(4);
			check(oc_live, 4'h1 << i);
			oc_ack = 4'hf;
			step(1);
			check(oc_flag, 4'h1 << i);
			oc_cmd = 0;
			step(4);
			oc_ack = 0;
			check(oc_flag, 4'h0);
		end
		check(port_powered, 4'hf);
		$display("test overcurrent done");
	endtask : t_oc
	task t_gang;
		gang_mode = 1;
		step(2);
		check(port_power_ctl_oe, 4'hf);
		check({3'b0, shared_port_power_ctl_pullup}, 4'h1);
		check({3'b0, shared_port_power_ctl_oe}, 4'h0);
		check(port_powered, 4'hf);
		shared_oc = 1;
		step(4);
		check(oc_flag, 4'hf);
		shared_oc = 0;
		oc_ack = 4'hf;
		step(4);
		oc_ack = 0;
		check(oc_flag, 4'h0);
		// host switches the whole group off, then on again
		host_port_enable = 4'h0;
		step(2);
		check({3'b0, shared_port_power_ctl_oe}, 4'h1);
		check({3'b0, shared_port_power_ctl_out}, 4'h0);
		check(port_powered, 4'h0);
		host_port_enable = 4'hf;
		step(4);
		check(oc_flag, 4'h0);
		gang_mode = 0;
		step(4);
		check(oc_flag, 4'h0);
		check(port_power_ctl_pullup, 4'hf);
		$display("test gang done");
	endtask : t_gang
	task t_bus;
		bus_power_sense = 1;
		wait_connect();
		check({3'b0, n >= settle_cycles && n <= settle_cycles + 4}, 4'h1);
		bus_power_sense = 0;
		n = 0;
		while (reneg_pulse !== 1'b1 && n < 5) begin
			step(1);
			n++;
		end
		check({3'b0, reneg_pulse}, 4'h1);
		if (reneg_pulse !== 1'b1) begin
			stop_test();
		end
		bus_power_sense = 1;
		step(1);
		check({3'b0, upstream_connect}, 4'h0);
		wait_connect();
		check({3'b0, upstream_connect}, 4'h1);
		// hold time and settle time both pass before reconnecting
		check({3'b0, n >= reneg_cycles + settle_cycles - 2 && n <= reneg_cycles + settle_cycles + 4}, 4'h1);
		$display("test bus power done");
	endtask : t_bus
	initial begin
		step(4);
		check(port_power_ctl_oe, 4'hf);
		check(port_power_ctl_pullup, 4'h0);
		check(oc_flag, 4'h0);
		check({3'b0, upstream_connect}, 4'h0);
		sys_rst = 0;
		step(1);
		t_enable();
		t_oc();
		t_gang();
		t_bus();
		stop_test();
	end
endmodule : port_power_ctl_bench
